// File: common/wdt_map.vh
// register offsets, field positions, reset values and counts of the watchdog
// assumes a 32-bit classic wishbone slave decoded on adr[4:2]
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// word indices on adr[4:2]
`define WDT_IDX_CTRL      3'h0
`define WDT_IDX_KEY       3'h1
`define WDT_IDX_STAT      3'h2
`define WDT_IDX_MASK      3'h3
`define WDT_IDX_CFG       3'h4
`define WDT_IDX_COUNT     3'h5

// watchdog_control fields
`define WDT_RUN           7
`define WDT_ISEL_HI       5
`define WDT_ISEL_LO       4
`define WDT_TOF           3
`define WDT_CAUSE         2
`define WDT_RSTEN         1
`define WDT_RESTART       0

// config fields
`define WDT_CFG_CLKSRC    7
`define WDT_CFG_TOIE      1
`define WDT_CFG_GIE       0

// status and mask fields
`define WDT_ST_TIMEOUT    0
`define WDT_ST_WDRESET    1
`define WDT_ST_W          2

// reset values
`define WDT_ISEL_RST      2'h0
`define WDT_CFG_RST       8'h00

// timed access
`define WDT_KEY1          8'haa
`define WDT_KEY2          8'h55
`define WDT_TA_WINDOW     3'h4

// counts in clocks and machine cycles, and the hold counter width
`define WDT_POST_LAST     10'h1ff
`define WDT_MC_CLKS       4
`define WDT_RST_MCS       2
`define WDT_HOLD_W        4

`endif

// File: rtl/wdt_sync.v
// two flip-flop synchroniser for level inputs from outside the clock domain
// assumes an active-low asynchronous clear that forces the output low
`timescale 1ns/100ps

module wdt_sync #(
	parameter W = 1
) (
	// clock and clear
	input  wire         clk,
	input  wire         clrN,
	// level in and out
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);

	reg [W-1:0] meta;

	always @(posedge clk or negedge clrN)
	begin
		if (!clrN)
		begin
			meta <= {W{1'b0}};
			q    <= {W{1'b0}};
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule // wdt_sync

// File: rtl/wdt_watchdog_timer.v
// watchdog divider with time-out flag, interrupt, delayed system reset and
// timed-access protected control, reached over a classic wishbone slave
// assumes one clock core_clk, pins rcClk/extReset/powerFail asynchronous
//
// Function
// - writing restart clears the count; the restart bit then clears itself.
// - interval select 00..11 gives 4096, 65536, 262144, 1048576 clocks.
// - interval elapse sets the time-out flag in control bit 3.
// - interrupt request needs time-out enable and global enable; reset path separate.
// - 512 clocks after time-out, with reset enabled and no restart, reset.
// - watchdog reset lasts two machine cycles and sets cause flag, bit 2.
// - reset-enable bit 1 clear blocks reset only; counting and flagging go on.
// - flag is set again on every further full interval.
// - time-out flag cleared by software writing zero or by any reset.
// - cause flag cleared only by software, power-fail or power-on; not set when disabled.
// - power-on or power-fail reset stops the watchdog; watchdog reset restarts it.
// - watchdog reset sets cause, power-on clears, external keeps; all clear enable.
// - after reset the interval select is the shortest, 4096 clocks.
// - run, select, enable, flag and restart writes need timed access.
// - config bit 7 picks internal rc clock or core clock for divider.
`timescale 1ns/100ps
`include "wdt_map.vh"

module wdt_watchdog_timer #(
	parameter [20:0] INTERVAL0 = 21'd4096,
	parameter [20:0] INTERVAL1 = 21'd65536,
	parameter [20:0] INTERVAL2 = 21'd262144,
	parameter [20:0] INTERVAL3 = 21'd1048576
) (
	// clock, reset, enable
	input  wire        core_clk,
	input  wire        nrst,
	input  wire        ce,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [4:2]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// pins and reset causes
	input  wire        rcClk,
	input  wire        extReset,
	input  wire        powerFail,
	// results
	output reg         sysReset,
	output reg         wdIrqReq,
	output reg         irq
);

	localparam [2:0] TA_IDLE = 3'b001;
	localparam [2:0] TA_GOT1 = 3'b010;
	localparam [2:0] TA_OPEN = 3'b100;
	localparam integer HOLD_PRODUCT = `WDT_MC_CLKS * `WDT_RST_MCS;
	localparam [`WDT_HOLD_W-1:0] HOLD_CLKS = HOLD_PRODUCT[`WDT_HOLD_W-1:0];

	// interval length in clocks for a select code
	function [20:0] intervalOf;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    intervalOf = INTERVAL0;
				2'h1:    intervalOf = INTERVAL1;
				2'h2:    intervalOf = INTERVAL2;
				default: intervalOf = INTERVAL3;
			endcase
		end
	endfunction

	wire        rstN;
	wire [2:0]  pinSync;
	reg         rcLast;
	reg         run;
	reg  [1:0]  isel;
	reg         timeoutFlag;
	reg         causeFlag;
	reg         rstEnable;
	reg         restartBit;
	reg  [7:0]  cfg;
	reg  [19:0] count;
	reg  [9:0]  postCount;
	reg         postActive;
	reg  [`WDT_HOLD_W-1:0] holdCount;
	reg  [2:0]  taState;
	reg  [2:0]  taCount;
	reg  [`WDT_ST_W-1:0] stat;
	reg  [`WDT_ST_W-1:0] mask;
	reg  [31:0] readMux;

	wire rcSync    = pinSync[0];
	wire extRstS   = pinSync[1];
	wire pfailS    = pinSync[2];
	wire request   = wb_cyc_i & wb_stb_i;
	wire wrLane    = request & wb_ack_o & wb_we_i & wb_sel_i[0];
	wire wrCtrl    = wrLane & (wb_adr_i == `WDT_IDX_CTRL);
	wire wrKey     = wrLane & (wb_adr_i == `WDT_IDX_KEY);
	wire wrStat    = wrLane & (wb_adr_i == `WDT_IDX_STAT);
	wire wrMask    = wrLane & (wb_adr_i == `WDT_IDX_MASK);
	wire wrCfg     = wrLane & (wb_adr_i == `WDT_IDX_CFG);
	wire taOpen    = (taState == TA_OPEN);
	wire wrProt    = wrCtrl & taOpen;
	wire [20:0] limit = intervalOf(isel) - 21'd1;
	wire tick      = run & (cfg[`WDT_CFG_CLKSRC] ? (rcSync & ~rcLast) : 1'b1);
	wire restartGo = restartBit;
	wire timeoutEv = tick & ~restartGo & ({1'b0, count} == limit);
	wire postEnd   = tick & ~restartGo & postActive & (postCount == `WDT_POST_LAST);
	wire wdFire    = postEnd & rstEnable;

	// reset release and pin synchronisers
	wdt_sync #(.W(1)) uRstSync (
		.clk  (core_clk),
		.clrN (nrst),
		.d    (1'b1),
		.q    (rstN)
	);

	wdt_sync #(.W(3)) uPinSync (
		.clk  (core_clk),
		.clrN (rstN),
		.d    ({powerFail, extReset, rcClk}),
		.q    (pinSync)
	);

	// divider, post-timeout span and system reset pulse
	always @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			rcLast     <= 1'b0;
			count      <= 20'h00000;
			postCount  <= 10'h000;
			postActive <= 1'b0;
			holdCount  <= {`WDT_HOLD_W{1'b0}};
			sysReset   <= 1'b0;
		end
		else if (ce)
		begin
			rcLast <= rcSync;
			if (pfailS | extRstS | wdFire | restartGo)
			begin
				count      <= 20'h00000;
				postCount  <= 10'h000;
				postActive <= 1'b0;
			end
			else if (tick)
			begin
				if (timeoutEv)
					count <= 20'h00000;
				else
					count <= count + 20'h00001;
				if (postActive)
				begin
					// back to zero so a later span again lasts the full count
					if (postCount == `WDT_POST_LAST)
					begin
						postCount  <= 10'h000;
						postActive <= 1'b0;
					end
					else
						postCount <= postCount + 10'h001;
				end
				else if (timeoutEv)
					postActive <= 1'b1;
			end
			if (wdFire)
			begin
				holdCount <= HOLD_CLKS;
				sysReset  <= 1'b1;
			end
			else if (holdCount != {`WDT_HOLD_W{1'b0}})
			begin
				holdCount <= holdCount - {{(`WDT_HOLD_W-1){1'b0}}, 1'b1};
				sysReset  <= (holdCount != {{(`WDT_HOLD_W-1){1'b0}}, 1'b1});
			end
		end
	end

	// timed-access key sequence
	always @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			taState <= TA_IDLE;
			taCount <= 3'h0;
		end
		else if (ce)
		begin
			case (taState)
				TA_IDLE:
				begin
					if (wrKey && wb_dat_i[7:0] == `WDT_KEY1)
						taState <= TA_GOT1;
				end
				TA_GOT1:
				begin
					if (wrKey && wb_dat_i[7:0] == `WDT_KEY2)
					begin
						taState <= TA_OPEN;
						taCount <= `WDT_TA_WINDOW;
					end
					else if (wrLane)
						taState <= TA_IDLE;
				end
				TA_OPEN:
				begin
					taCount <= taCount - 3'h1;
					if (wrCtrl || taCount == 3'h1)
						taState <= TA_IDLE;
				end
				default:
					taState <= TA_IDLE;
			endcase
		end
	end

	// watchdog_control and config
	always @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			run         <= 1'b0;
			isel        <= `WDT_ISEL_RST;
			timeoutFlag <= 1'b0;
			causeFlag   <= 1'b0;
			rstEnable   <= 1'b0;
			restartBit  <= 1'b0;
			cfg         <= `WDT_CFG_RST;
			wdIrqReq    <= 1'b0;
		end
		else if (ce)
		begin
			wdIrqReq <= timeoutFlag & cfg[`WDT_CFG_TOIE] & cfg[`WDT_CFG_GIE];
			if (wrCfg)
				cfg <= wb_dat_i[7:0];
			if (pfailS)
			begin
				run         <= 1'b0;
				isel        <= `WDT_ISEL_RST;
				timeoutFlag <= 1'b0;
				causeFlag   <= 1'b0;
				rstEnable   <= 1'b0;
				restartBit  <= 1'b0;
			end
			else if (extRstS)
			begin
				run         <= 1'b0;
				isel        <= `WDT_ISEL_RST;
				timeoutFlag <= 1'b0;
				rstEnable   <= 1'b0;
				restartBit  <= 1'b0;
			end
			else if (wdFire)
			begin
				isel        <= `WDT_ISEL_RST;
				timeoutFlag <= 1'b0;
				causeFlag   <= 1'b1;
				rstEnable   <= 1'b0;
				restartBit  <= 1'b0;
			end
			else
			begin
				restartBit <= wrProt & wb_dat_i[`WDT_RESTART];
				if (timeoutEv)
					timeoutFlag <= 1'b1;
				else if (wrProt && !wb_dat_i[`WDT_TOF])
					timeoutFlag <= 1'b0;
				if (wrCtrl && !wb_dat_i[`WDT_CAUSE])
					causeFlag <= 1'b0;
				if (wrProt)
				begin
					run       <= wb_dat_i[`WDT_RUN];
					isel      <= wb_dat_i[`WDT_ISEL_HI:`WDT_ISEL_LO];
					rstEnable <= wb_dat_i[`WDT_RSTEN];
				end
			end
		end
	end

	// interrupt status, mask and output
	always @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			stat <= {`WDT_ST_W{1'b0}};
			mask <= {`WDT_ST_W{1'b0}};
			irq  <= 1'b0;
		end
		else if (ce)
		begin
			// a new event wins over a clearing write
			stat <= (stat & ~({`WDT_ST_W{wrStat}} & wb_dat_i[`WDT_ST_W-1:0]))
				| {wdFire, timeoutEv};
			if (wrMask)
				mask <= wb_dat_i[`WDT_ST_W-1:0];
			irq <= |(stat & mask);
		end
	end

	// register read selection
	always @*
	begin
		readMux = 32'h00000000;
		case (wb_adr_i)
			`WDT_IDX_CTRL:
				readMux[7:0] = {run, 1'b0, isel, timeoutFlag, causeFlag, rstEnable,
					restartBit};
			`WDT_IDX_KEY:
				readMux[0] = taOpen;
			`WDT_IDX_STAT:
				readMux[`WDT_ST_W-1:0] = stat;
			`WDT_IDX_MASK:
				readMux[`WDT_ST_W-1:0] = mask;
			`WDT_IDX_CFG:
				readMux[7:0] = cfg;
			`WDT_IDX_COUNT:
				readMux[19:0] = count;
			default:
				readMux = 32'h00000000;
		endcase
	end

	// wishbone answer one cycle after the request
	always @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else if (ce)
		begin
			wb_ack_o <= request & ~wb_ack_o;
			if (request && !wb_ack_o)
				wb_dat_o <= readMux;
		end
	end

endmodule // wdt_watchdog_timer

// File: verification/wdt_watchdog_timer_properties.sv
// checker of bus answers, reset pulse and interrupt outputs of the watchdog
// assumes ce is held high and sees only the top ports
`timescale 1ns/100ps

module wdt_watchdog_timer_properties (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        nrst,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [4:2]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// pins and results
	input wire logic        powerFail,
	input wire logic        sysReset,
	input wire logic        wdIrqReq,
	input wire logic        irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire rdAck = wb_ack_o && !wb_we_i;
	wire wrAck = wb_ack_o && wb_we_i;

	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	ack_idle_a: assert property (!wb_stb_i |=> !wb_ack_o)
		else $error("ack without request");
	reset_hold_a: assert property ($rose(sysReset) |-> sysReset[*8] ##1 !sysReset)
		else $error("watchdog reset not eight clocks");
	fail_clear_a: assert property (powerFail[*6] |=> !wdIrqReq)
		else $error("interrupt request survives power fail");
	unmap_zero_a: assert property (rdAck && wb_adr_i[4:3] == 2'b11 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	ctrl_spare_a: assert property (rdAck && wb_adr_i == 3'h0 |-> wb_dat_o[31:8] == 24'h0 && !wb_dat_o[6])
		else $error("control spare bits set");
	irq_fall_a: assert property ($fell(irq) |-> $past(wrAck, 2))
		else $error("irq dropped without a write");

	cover property ($rose(sysReset));
	cover property ($fell(irq));
	cover property (rdAck && wb_adr_i[4:3] == 2'b11);
endmodule // wdt_watchdog_timer_properties

bind wdt_watchdog_timer wdt_watchdog_timer_properties chk (.*);

// File: verification/wdt_watchdog_timer_test.sv
// self-checking bench of the watchdog: registers, intervals, irq and resets
// assumes the checker binds itself; intervals shortened to 16..128
`timescale 1ns/100ps

module wdt_watchdog_timer_test;
	reg          core_clk = 0, nrst = 0, cyc = 0, we = 0, extReset = 0, powerFail = 0;
	reg          rcClk = 0;
	reg  [3:0]   sel = 4'hf;
	reg  [2:0]   adr = 0;
	reg  [31:0]  dat = 0;
	reg  [7:0]   rnd = 8'h56;
	wire [31:0]  rdat;
	wire         ack, sysReset, wdIrqReq, irq;
	integer      failures = 0, num_checks = 0, cycles = 0, rstCycles = 0, t0, t1, n, k;
	logic [31:0] expQ[$], mskQ[$];
	string       nameQ[$];

	wdt_watchdog_timer #(.INTERVAL0(21'd16), .INTERVAL1(21'd32), .INTERVAL2(21'd64),
		.INTERVAL3(21'd128)) dut (.core_clk(core_clk), .nrst(nrst), .ce(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rcClk(rcClk),
		.extReset(extReset), .powerFail(powerFail), .sysReset(sysReset),
		.wdIrqReq(wdIrqReq), .irq(irq));

	initial forever #25 core_clk = ~core_clk;

	function [7:0] lfsr(input [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task print_verdict;
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input [31:0] e, g);
		num_checks++;
		if (e !== g)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wb(input w, input [2:0] a, input [7:0] d);
		cyc <= 1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		@(posedge core_clk);
		while (ack !== 1'b1)
			@(posedge core_clk);
		cyc <= 0;
		@(posedge core_clk);
	endtask
	task rd(input string nm, input [2:0] a, input [7:0] e, m);
		expQ.push_back({24'h0, e & m});
		mskQ.push_back({24'hffffff, m});
		nameQ.push_back(nm);
		wb(0, a, 8'h0);
	endtask
	task prot(input [7:0] d);
		wb(1, 1, 8'haa);
		wb(1, 1, 8'h55);
		wb(1, 0, d);
	endtask
	// time at which irq is next seen, then clear the time-out status bit
	task waitirq;
		@(posedge core_clk);
		n = 0;
		while (irq !== 1'b1 && n < 400)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n == 400)
			failures++;
		t0 = cycles;
		wb(1, 2, 8'h01);
	endtask

	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (sysReset === 1'b1)
			rstCycles++;
		if (ack === 1'b1 && !we && expQ.size() > 0)
			chk(nameQ.pop_front(), expQ.pop_front(), rdat & mskQ.pop_front());
		if (cycles == 6000)
		begin
			failures++;
			print_verdict;
		end
	end

	initial
	begin
		repeat (6) @(posedge core_clk);
		nrst <= 1;
		repeat (3) @(posedge core_clk);
		rd("control", 0, 8'h00, 8'hff);
		rd("config", 4, 8'h00, 8'hff);
		for (k = 0; k < 4; k++)
		begin
			rnd = lfsr(rnd);
			wb(1, 7, rnd);
			rd("unmapped", 7, 8'h00, 8'hff);
			wb(1, 3, rnd);
			rd("mask", 3, rnd & 8'h03, 8'hff);
		end
		// low byte lane off: the write must be dropped
		sel <= 4'he;
		wb(1, 3, ~rnd);
		sel <= 4'hf;
		rd("mask ignored", 3, rnd & 8'h03, 8'hff);
		wb(1, 0, 8'h80);
		rd("locked control", 0, 8'h00, 8'hff);
		wb(1, 3, 8'h01);
		wb(1, 4, 8'h03);
		for (k = 0; k < 4; k++)
		begin
			prot(8'h81 | 8'(k << 4));
			waitirq;
			t1 = t0;
			waitirq;
			chk("interval", 32'd16 << k, 32'(t0 - t1));
		end
		rd("timeout flag", 0, 8'h08, 8'h08);
		chk("irq request", 1, wdIrqReq);
		wb(1, 4, 8'h02);
		@(posedge core_clk);
		chk("irq request off", 0, wdIrqReq);
		repeat (300) @(posedge core_clk);
		chk("reset cycles", 0, rstCycles);
		prot(8'h83);
		wb(1, 2, 8'h01);
		waitirq;
		t1 = t0;
		n = 0;
		while (sysReset !== 1'b1 && n < 1000)
		begin
			@(posedge core_clk);
			n++;
		end
		// irq is seen one clock after the flag, sysReset rises 512 after it
		chk("reset delay", 32'd512 - 32'd1, 32'(cycles - t1));
		repeat (12) @(posedge core_clk);
		chk("reset length", 8, rstCycles);
		rd("after watchdog reset", 0, 8'h84, 8'hf6);
		rd("reset event", 2, 8'h02, 8'h02);
		extReset <= 1;
		repeat (6) @(posedge core_clk);
		extReset <= 0;
		repeat (3) @(posedge core_clk);
		rd("after external reset", 0, 8'h04, 8'hfe);
		powerFail <= 1;
		repeat (6) @(posedge core_clk);
		powerFail <= 0;
		repeat (3) @(posedge core_clk);
		rd("after power fail", 0, 8'h00, 8'hfe);
		// divider stepped by rising rc clock edges only
		wb(1, 4, 8'h80);
		prot(8'h81);
		for (k = 0; k < 16; k++)
		begin
			if (k == 15)
				rd("rc fifteen edges", 0, 8'h00, 8'h08);
			rcClk <= 1;
			repeat (3) @(posedge core_clk);
			rcClk <= 0;
			repeat (3) @(posedge core_clk);
		end
		repeat (3) @(posedge core_clk);
		rd("rc sixteen edges", 0, 8'h08, 8'h08);
		print_verdict;
	end
endmodule // wdt_watchdog_timer_test
